// File: design/laa_pkg.sv
/*
  Shared constants for the locality abort arbiter: access register field positions,
  locality count, address window decoding and abort timing limits.
  Assumes a 125 MHz device clock and a register access port carrying 16-bit addresses.
*/
package laa_pkg;

  localparam int unsigned LAA_NUM_LOC = 5;
  localparam logic [2:0] LAA_LOC_HASH = 3'h4;

  // Access register field positions.
  localparam int unsigned LAA_BIT_ENV = 0;
  localparam int unsigned LAA_BIT_REQ = 1;
  localparam int unsigned LAA_BIT_PEND = 2;
  localparam int unsigned LAA_BIT_TAKE = 3;
  localparam int unsigned LAA_BIT_TAKEN = 4;
  localparam int unsigned LAA_BIT_ACTIVE = 5;
  localparam int unsigned LAA_BIT_VALID = 7;

  // Register offsets within each locality window; the locality sits in address bits 14:12.
  localparam logic [11:0] LAA_OFS_ACCESS = 12'h000;
  localparam logic [11:0] LAA_OFS_STATUS = 12'h018;
  localparam logic [11:0] LAA_OFS_HASH_START = 12'h028;
  localparam int unsigned LAA_LOC_LSB = 12;

  // Status register command-ready field.
  localparam int unsigned LAA_BIT_CMD_READY = 6;

  // Reset values.
  localparam logic LAA_RST_TAKEN = 1'b0;
  localparam logic LAA_RST_REQ = 1'b0;
  localparam logic [2:0] LAA_RST_ACTIVE_LOC = 3'h0;

  // Abort answer limits in nanoseconds and the clock period.
  localparam int unsigned LAA_CLK_PERIOD_NS = 8;
  localparam int unsigned LAA_TIMEOUT_A_NS = 750000;
  localparam int unsigned LAA_TIMEOUT_B_NS = 2000000;
  localparam int unsigned LAA_TIMEOUT_A_CYC = LAA_TIMEOUT_A_NS / LAA_CLK_PERIOD_NS;
  localparam int unsigned LAA_TIMEOUT_B_CYC = LAA_TIMEOUT_B_NS / LAA_CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    LAA_ST_IDLE = 4'b0001,
    LAA_ST_RECEIVE = 4'b0010,
    LAA_ST_EXECUTE = 4'b0100,
    LAA_ST_ABORT = 4'b1000
  } laa_cmd_state_t;

endpackage

// File: design/laa_sync2.sv
/*
  Two flip-flop synchroniser for a single level.
  Assumes the input is asynchronous to clk and only the second stage is read.
*/
`timescale 1ns/10ps
module laa_sync2 (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: design/laa_abort_timer.sv
/*
  Abort answer timer: counts cycles while an abort is outstanding and flags overrun
  of the limit chosen by the command class.
  Assumes start pulses once per abort and done ends the wait.
*/
`timescale 1ns/10ps
module laa_abort_timer #(
  parameter int unsigned LIMIT_A = laa_pkg::LAA_TIMEOUT_A_CYC,
  parameter int unsigned LIMIT_B = laa_pkg::LAA_TIMEOUT_B_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic done,
  input wire logic long_class,
  output logic overrun
);

  logic [17:0] count;
  logic running;
  logic [17:0] limit;
  wire [17:0] lim_a = 18'(LIMIT_A);
  wire [17:0] lim_b = 18'(LIMIT_B);
  wire at_limit = running && (count >= limit);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 18'h00000;
      running <= 1'b0;
      limit <= 18'h00000;
      overrun <= 1'b0;
    end else begin
      if (start) begin
        count <= 18'h00000;
        running <= 1'b1;
        limit <= long_class ? lim_b : lim_a;
      end else if (done) begin
        running <= 1'b0;
      end else if (running && !at_limit) begin
        count <= count + 18'h00001;
      end
      overrun <= at_limit && !done;
    end
  end

endmodule

// File: design/laa_arbiter.sv
/*
  Locality arbiter and command abort control for a security module register interface.
  Assumes a synchronous register access port (wr_en/rd_en with 16-bit address, byte data)
  from the bus front end on ref_clk, and a command engine that reports receive/execute
  phases and acknowledges flush requests. The permanent environment flag is a pin.
*/
`timescale 1ns/10ps

module laa_arbiter (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic cmd_receiving,
  input wire logic cmd_executing,
  input wire logic cmd_long_class,
  input wire logic flush_done,
  input wire logic env_established_perm,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic abort_req,
  output logic fifo_flush,
  output logic cmd_engine_idle,
  output logic [2:0] active_loc,
  output logic any_active,
  output logic hash_accept,
  output logic resp_release,
  output logic abort_overrun
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the locality window and register within it.

  function automatic logic [4:0] laa_onehot(input logic [2:0] loc);
    laa_onehot = 5'h00;
    if (loc < 3'h5) begin
      laa_onehot[loc] = 1'b1;
    end
  endfunction

  wire [2:0] acc_loc = addr[14:12];
  wire [11:0] acc_ofs = addr[11:0];
  wire loc_ok = (acc_loc < 3'h5) && (addr[15] == 1'b0);
  wire hit_access = loc_ok && (acc_ofs == laa_pkg::LAA_OFS_ACCESS);
  wire hit_status = loc_ok && (acc_ofs == laa_pkg::LAA_OFS_STATUS);
  wire hit_hash = loc_ok && (acc_loc == laa_pkg::LAA_LOC_HASH) && (acc_ofs == laa_pkg::LAA_OFS_HASH_START);
  wire [4:0] acc_sel = laa_onehot(acc_loc);

  ////////////////////////////////////////////////////////////////////////////////
  // Environment flag pin synchroniser.

  logic env_perm_sync;

  laa_sync2 u_env_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .async_in(env_established_perm),
    .sync_out(env_perm_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Locality state.

  wire [4:0] use_request_flag;
  wire [4:0] taken_over_flag;
  logic [1:0] valid_stage;
  // Valid waits for the pin synchroniser to fill, so the environment bit has settled first.
  wire valid_done = valid_stage[1];
  logic [4:0] next_request;
  logic [4:0] next_taken;
  logic next_any_active;
  logic [2:0] next_active_loc;

  wire is_active_acc = any_active && (acc_loc == active_loc);
  wire wr_acc = wr_en && hit_access;
  // Fields written as zero take no part in any decision below.
  wire w_req = wr_acc && wdata[laa_pkg::LAA_BIT_REQ];
  wire w_take = wr_acc && wdata[laa_pkg::LAA_BIT_TAKE];
  wire w_taken_clr = wr_acc && wdata[laa_pkg::LAA_BIT_TAKEN];
  wire w_active = wr_acc && wdata[laa_pkg::LAA_BIT_ACTIVE];
  // Takeover from a lower or equal locality, or with nobody active, is refused.
  wire take_ok = w_take && any_active && (acc_loc > active_loc);
  wire release_ok = w_active && is_active_acc;
  wire cancel_ok = w_active && !is_active_acc && use_request_flag[acc_loc];
  // A multi-field write resolves in fixed priority: takeover, release, request, then cancel.

  // Highest-numbered pending request after this cycle's cancel and new request.
  logic [4:0] req_after;
  logic grant_found;
  logic [2:0] grant_loc;

  always_comb begin
    req_after = use_request_flag;
    if (cancel_ok) begin
      req_after = req_after & ~acc_sel;
    end
    if (w_req && !is_active_acc && !take_ok && !release_ok) begin
      req_after = req_after | acc_sel;
    end
    grant_found = 1'b0;
    grant_loc = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (req_after[i]) begin
        grant_found = 1'b1;
        grant_loc = 3'(i);
      end
    end
  end

  always_comb begin
    next_request = req_after;
    next_taken = taken_over_flag;
    next_any_active = any_active;
    next_active_loc = active_loc;
    if (w_taken_clr) begin
      next_taken = next_taken & ~acc_sel;
    end
    if (take_ok) begin
      // Setting after the clear lets a takeover in the same cycle win.
      next_taken = next_taken | laa_onehot(active_loc);
      next_active_loc = acc_loc;
      next_request = next_request & ~acc_sel;
    end else if (release_ok || !any_active) begin
      // With nobody active a fresh request is granted at once.
      next_any_active = grant_found;
      next_active_loc = grant_found ? grant_loc : active_loc;
      if (grant_found) begin
        next_request = next_request & ~laa_onehot(grant_loc);
      end
    end
  end

  // Each locality keeps its own flag pair.
  for (genvar g = 0; g < laa_pkg::LAA_NUM_LOC; g++) begin : g_flags
    logic request_bit;
    logic taken_bit;

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        request_bit <= laa_pkg::LAA_RST_REQ;
        taken_bit <= laa_pkg::LAA_RST_TAKEN;
      end else begin
        request_bit <= next_request[g];
        taken_bit <= next_taken[g];
      end
    end

    assign use_request_flag[g] = request_bit;
    assign taken_over_flag[g] = taken_bit;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      any_active <= 1'b0;
      active_loc <= laa_pkg::LAA_RST_ACTIVE_LOC;
      valid_stage <= 2'h0;
    end else begin
      any_active <= next_any_active;
      active_loc <= next_active_loc;
      valid_stage <= {valid_stage[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Abort triggers and command engine tracking.

  wire cmd_ready_wr = wr_en && hit_status && wdata[laa_pkg::LAA_BIT_CMD_READY];
  wire trig_ready_exec = cmd_ready_wr && cmd_executing;
  wire trig_ready_recv = cmd_ready_wr && cmd_receiving;
  wire trig_take = take_ok;
  wire trig_active = w_active && (release_ok || cancel_ok);
  // Hash start is taken only while no locality is active.
  wire hash_ok = wr_en && hit_hash && !any_active;
  wire trig_hash = hash_ok;
  // Every takeover, release or cancel aborts so a response cannot reach a new owner; a grant with nobody active does not.
  wire trig_any = trig_ready_exec || trig_ready_recv || trig_take || trig_active || trig_hash;

  laa_pkg::laa_cmd_state_t state;
  laa_pkg::laa_cmd_state_t next_state;
  logic next_flush;

  always_comb begin
    next_state = state;
    next_flush = 1'b0;
    unique case (state)
      laa_pkg::LAA_ST_IDLE: begin
        if (trig_any && (cmd_receiving || cmd_executing)) begin
          next_state = laa_pkg::LAA_ST_ABORT;
          next_flush = 1'b1;
        end else if (cmd_executing) begin
          next_state = laa_pkg::LAA_ST_EXECUTE;
        end else if (cmd_receiving) begin
          next_state = laa_pkg::LAA_ST_RECEIVE;
        end
      end
      laa_pkg::LAA_ST_RECEIVE, laa_pkg::LAA_ST_EXECUTE: begin
        if (trig_any) begin
          next_state = laa_pkg::LAA_ST_ABORT;
          next_flush = 1'b1;
        end else if (cmd_executing) begin
          next_state = laa_pkg::LAA_ST_EXECUTE;
        end else if (cmd_receiving) begin
          next_state = laa_pkg::LAA_ST_RECEIVE;
        end else begin
          next_state = laa_pkg::LAA_ST_IDLE;
        end
      end
      laa_pkg::LAA_ST_ABORT: begin
        // The engine acknowledges only at a whole-command boundary.
        if (flush_done) begin
          next_state = laa_pkg::LAA_ST_IDLE;
        end
      end
      default: begin
        next_state = laa_pkg::LAA_ST_IDLE;
      end
    endcase
  end

  wire abort_start = (state != laa_pkg::LAA_ST_ABORT) && (next_state == laa_pkg::LAA_ST_ABORT);
  logic overrun_raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Command ownership.

  // A command's owner is latched as it starts, so its response never reaches a later owner.
  logic [2:0] cmd_owner;
  logic cmd_owned;
  wire next_in_flight = (next_state == laa_pkg::LAA_ST_RECEIVE) || (next_state == laa_pkg::LAA_ST_EXECUTE);
  wire cmd_start = (state == laa_pkg::LAA_ST_IDLE) && next_in_flight;
  wire [2:0] next_cmd_owner = cmd_start ? active_loc : cmd_owner;
  wire next_cmd_owned = next_in_flight && (cmd_start ? any_active : cmd_owned);
  wire owner_ok = !next_in_flight || (next_cmd_owned && (next_cmd_owner == next_active_loc));

  // The timer only watches the engine; it cannot force a faster answer.
  laa_abort_timer u_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(abort_start),
    .done(flush_done),
    .long_class(cmd_long_class),
    .overrun(overrun_raw)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= laa_pkg::LAA_ST_IDLE;
      abort_req <= 1'b0;
      fifo_flush <= 1'b0;
      cmd_engine_idle <= 1'b1;
      hash_accept <= 1'b0;
      resp_release <= 1'b0;
      abort_overrun <= 1'b0;
      cmd_owner <= laa_pkg::LAA_RST_ACTIVE_LOC;
      cmd_owned <= 1'b0;
    end else begin
      state <= next_state;
      abort_req <= next_state == laa_pkg::LAA_ST_ABORT;
      fifo_flush <= next_flush;
      cmd_engine_idle <= next_state == laa_pkg::LAA_ST_IDLE;
      hash_accept <= hash_ok;
      // Responses flow only while the owner is unchanged and no abort is pending.
      resp_release <= next_any_active && (next_active_loc == active_loc) && any_active &&
                      (next_state != laa_pkg::LAA_ST_ABORT) && owner_ok;
      abort_overrun <= overrun_raw;
      cmd_owner <= next_cmd_owner;
      cmd_owned <= next_cmd_owned;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-locality access register read view.

  wire [7:0] loc_view [laa_pkg::LAA_NUM_LOC];

  for (genvar g = 0; g < laa_pkg::LAA_NUM_LOC; g++) begin : g_view
    wire [4:0] own_sel = laa_onehot(3'(g));
    wire own_active = any_active && (active_loc == 3'(g));
    wire own_request = |(use_request_flag & own_sel);
    wire own_taken = |(taken_over_flag & own_sel);
    wire other_request = |(use_request_flag & ~own_sel);
    logic [7:0] one_view;

    always_comb begin
      one_view = 8'h00;
      one_view[laa_pkg::LAA_BIT_VALID] = valid_done;
      one_view[laa_pkg::LAA_BIT_ACTIVE] = own_active;
      one_view[laa_pkg::LAA_BIT_TAKEN] = own_taken;
      one_view[laa_pkg::LAA_BIT_PEND] = other_request;
      one_view[laa_pkg::LAA_BIT_REQ] = own_request;
      one_view[laa_pkg::LAA_BIT_ENV] = ~env_perm_sync;
    end

    assign loc_view[g] = one_view;
  end

  // Localities outside the window fold onto zero; hit_access masks their view anyway.
  wire [2:0] view_loc = loc_ok ? acc_loc : 3'h0;
  wire [7:0] view = loc_view[view_loc];

  wire [7:0] next_rdata = hit_access ? view : 8'hFF;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= rd_en ? next_rdata : 8'h00;
      rvalid <= rd_en;
    end
  end

endmodule

// File: tb/laa_arbiter_sva.sv
/* Port checker for the locality arbiter.
   Assumes it is bound to laa_arbiter and sees only its ports. */
`timescale 1ns/10ps
module laa_arbiter_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic cmd_receiving,
  input wire logic cmd_executing,
  input wire logic flush_done,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic abort_req,
  input wire logic fifo_flush,
  input wire logic cmd_engine_idle,
  input wire logic [2:0] active_loc,
  input wire logic any_active,
  input wire logic hash_accept
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic [2:0] loc = addr[14:12];
  wire logic own = any_active && loc == active_loc && !addr[15];
  wire logic acc_wr = wr_en && !addr[15] && addr[11:0] == laa_pkg::LAA_OFS_ACCESS;
  wire logic sts_wr = wr_en && addr[11:0] == laa_pkg::LAA_OFS_STATUS && wdata == 8'h40;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_abort_start;
    abort_req && fifo_flush;
  endsequence
  sequence s_abort_end;
    !abort_req && cmd_engine_idle;
  endsequence
  a_status_abort: assert property (sts_wr && own && (cmd_receiving || cmd_executing) && !abort_req |=> s_abort_start)
    else $error("status write did not abort");
  a_release_abort: assert property (acc_wr && wdata == 8'h20 && own && cmd_executing && !abort_req |=> s_abort_start)
    else $error("release did not abort");
  a_flush_pulse: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush longer than one cycle");
  a_abort_done_idle: assert property (abort_req && flush_done |=> s_abort_end)
    else $error("abort did not end in idle");
  a_grant_free: assert property (acc_wr && wdata == 8'h02 && !any_active && loc <= 3'h4 |=> any_active && active_loc == $past(loc))
    else $error("free request not granted");
  a_take_higher: assert property (acc_wr && wdata == 8'h08 && any_active && loc > active_loc && loc <= 3'h4 |=> active_loc == $past(loc))
    else $error("takeover not granted");
  a_take_lower: assert property (acc_wr && wdata == 8'h08 && any_active && loc <= active_loc |=> $stable(active_loc) && any_active)
    else $error("lower takeover granted");
  a_hash_free: assert property (wr_en && addr == 16'h4028 && !any_active |=> hash_accept)
    else $error("hash start refused");
  a_unmapped_read: assert property (rd_en && addr[11:0] == 12'h0F0 |=> rvalid && rdata == 8'hFF)
    else $error("unmapped read not FF");
endmodule
bind laa_arbiter laa_arbiter_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en),
  .addr(addr), .wdata(wdata), .cmd_receiving(cmd_receiving), .cmd_executing(cmd_executing),
  .flush_done(flush_done), .rdata(rdata), .rvalid(rvalid), .abort_req(abort_req), .fifo_flush(fifo_flush),
  .cmd_engine_idle(cmd_engine_idle), .active_loc(active_loc), .any_active(any_active), .hash_accept(hash_accept));

// File: tb/laa_engine_model.sv
/* Command engine model facing the abort control.
   Assumes the bench starts phases and sets the flush answer delay. */
`timescale 1ns/10ps
module laa_engine_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start_rx,
  input wire logic start_ex,
  input wire logic [3:0] delay,
  input wire logic fifo_flush,
  output logic cmd_receiving,
  output logic cmd_executing,
  output logic flush_done
);
  logic [4:0] cnt;
  // Phases drop only together with done, so no half-aborted phase is visible.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_receiving <= 1'b0;
      cmd_executing <= 1'b0;
      flush_done <= 1'b0;
      cnt <= 5'h00;
    end else begin
      flush_done <= 1'b0;
      if (start_rx) cmd_receiving <= 1'b1;
      if (start_ex) cmd_executing <= 1'b1;
      if (fifo_flush) cnt <= {1'b0, delay} + 5'h01;
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        flush_done <= 1'b1;
        cmd_receiving <= 1'b0;
        cmd_executing <= 1'b0;
      end
    end
  end
endmodule

// File: tb/tb_locality_abort_arbiter.sv
/* Self-checking bench for laa_arbiter with a command engine model.
   Assumes a 125 MHz clock and single byte register strobes. */
`timescale 1ns/10ps
module tb_locality_abort_arbiter;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic cmd_long_class = 1'b0;
  logic env_established_perm = 1'b0;
  logic start_rx = 1'b0;
  logic start_ex = 1'b0;
  logic [3:0] delay = 4'h0;
  logic cmd_receiving, cmd_executing, flush_done, rvalid, abort_req, fifo_flush;
  logic cmd_engine_idle, any_active, hash_accept, resp_release, abort_overrun;
  logic [7:0] rdata;
  logic [2:0] active_loc;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int check_count = 0;
  always #4 ref_clk = ~ref_clk;
  laa_arbiter u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .cmd_receiving(cmd_receiving), .cmd_executing(cmd_executing), .cmd_long_class(cmd_long_class),
    .flush_done(flush_done), .env_established_perm(env_established_perm), .rdata(rdata), .rvalid(rvalid),
    .abort_req(abort_req), .fifo_flush(fifo_flush), .cmd_engine_idle(cmd_engine_idle), .active_loc(active_loc),
    .any_active(any_active), .hash_accept(hash_accept), .resp_release(resp_release),
    .abort_overrun(abort_overrun));
  laa_engine_model u_engine (.ref_clk(ref_clk), .arst_n(arst_n), .start_rx(start_rx), .start_ex(start_ex),
    .delay(delay), .fifo_flush(fifo_flush), .cmd_receiving(cmd_receiving), .cmd_executing(cmd_executing),
    .flush_done(flush_done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
    check_count++;
    if (seen !== expected) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, expected, seen);
    end
  endtask
  // Each access or status write sets at most one field.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1) check("rdata", rdata, exp_q.pop_front());
  end
  task automatic start_cmd(input logic rx);
    @(posedge ref_clk);
    start_rx <= rx;
    start_ex <= !rx;
    delay <= 4'($urandom);
    cmd_long_class <= 1'($urandom);
    @(posedge ref_clk);
    start_rx <= 1'b0;
    start_ex <= 1'b0;
  endtask
  // Bounded wait: the model answers within 17 cycles.
  task automatic wait_abort();
    int n;
    n = 0;
    while (abort_req !== 1'b0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check("abort end", 8'(n < 40), 8'h01);
    check("idle", 8'(cmd_engine_idle), 8'h01);
    check("overrun", 8'(abort_overrun), 8'h00);
  endtask
  // Kinds: 0 status in execute, 1 status in receive, 2 release, 3 hash start, 4 status with no command.
  task automatic abort_case(input int kind);
    if (kind != 3) wr(16'h0000, 8'h02);
    if (kind != 4) start_cmd(kind == 1);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("owner response", 8'(resp_release), 8'(kind != 3));
    if (kind == 2) wr(16'h0000, 8'h20);
    else if (kind == 3) wr(16'h4028, 8'($urandom));
    else wr(16'h0018, 8'h40);
    check("abort", 8'(abort_req), 8'(kind != 4));
    check("flush", 8'(fifo_flush), 8'(kind != 4));
    if (kind == 3) check("hash", 8'(hash_accept), 8'h01);
    wait_abort();
    if (kind < 2 || kind == 4) wr(16'h0000, 8'h20);
    check("response", 8'(resp_release), 8'h00);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 20000);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(50));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(16'h0000, 8'h01);
    rd(16'h0000, 8'h81);
    rd(16'h00F0, 8'hFF);
    @(posedge ref_clk);
    env_established_perm <= 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(16'h2000, 8'h80);
    $display("test reset view done");
    wr(16'h0000, 8'h02);
    wr(16'h1000, 8'h02);
    wr(16'h3000, 8'h02);
    rd(16'h3000, 8'h86);
    wr(16'h1000, 8'h20);
    rd(16'h1000, 8'h84);
    wr(16'h0000, 8'h20);
    check("owner", 8'(active_loc), 8'h03);
    rd(16'h3000, 8'hA0);
    wr(16'h3000, 8'h20);
    check("free", 8'(any_active), 8'h00);
    $display("test pending done");
    wr(16'h0000, 8'h02);
    start_cmd(1'b0);
    @(posedge ref_clk);
    wr(16'h2000, 8'h08);
    check("take", 8'(active_loc), 8'h02);
    check("take abort", 8'(abort_req), 8'h01);
    wait_abort();
    rd(16'h0000, 8'h90);
    wr(16'h0000, 8'h10);
    rd(16'h0000, 8'h80);
    wr(16'h1000, 8'h08);
    wr(16'h2000, 8'h00);
    rd(16'h2000, 8'hA0);
    check("new owner response", 8'(resp_release), 8'h01);
    wr(16'h2000, 8'h20);
    $display("test takeover done");
    for (int k = 0; k < 5; k++) abort_case(k);
    $display("test aborts done");
    summarize();
  end
endmodule
